// ===== src/dasc_pkg.sv
package dasc_pkg;
	// ==========================================
	// sizes
	localparam int DW   = 46;
	localparam int NCV  = 2;
	localparam int NCH  = 4;
	localparam int NSRC = 4;
	localparam int TW   = 6;
	// ==========================================
	// timing and gain
	localparam logic [7:0] MOD_RST_LAST = 8'h03;
	localparam logic [3:0] GEXP_MAX     = 4'h9;
	localparam logic [7:0] OSR_RST      = 8'h40;
	// ==========================================
	// register byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_OSR   = 8'h04;
	localparam logic [7:0] A_GAIN  = 8'h08;
	localparam logic [7:0] A_AGC   = 8'h0c;
	localparam logic [7:0] A_TRIG  = 8'h10;
	localparam logic [7:0] A_CMD   = 8'h14;
	localparam logic [7:0] A_ROUTE = 8'h18;
	localparam logic [7:0] A_STAT  = 8'h1c;
	localparam logic [7:0] A_RES0  = 8'h20;
	localparam logic [7:0] A_RES3  = 8'h2c;
	// ==========================================
	// field positions
	localparam int CTRL_INCR  = 0;
	localparam int CTRL_CHOP  = 1;
	localparam int CTRL_AGC   = 2;
	localparam int CTRL_HV16  = 3;
	localparam int CTRL_RUN   = 4;
	localparam int CTRL_SYNCT = 5;
	localparam int CMD_SW     = 0;
	localparam int CMD_SYNC   = 1;
	localparam int SRC_SW     = 0;
	localparam int SRC_TMR    = 1;
	localparam int SRC_GPIO   = 2;
	localparam int SRC_EOC    = 3;
	// ==========================================
	// reset values
	localparam logic [5:0]  CTRL_RST  = 6'h04;
	localparam logic [7:0]  GAIN_RST  = 8'h00;
	localparam logic [31:0] AGC_RST   = 32'h0100_4000;
	localparam logic [23:0] TRIG_RST  = 24'h00_0000;
	localparam logic [3:0]  ROUTE_RST = 4'ha;
	// ==========================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RST  = 3'b010,
		ST_CONV = 3'b100
	} dasc_st_e;
	typedef logic signed [DW-1:0] dasc_acc_t;
endpackage

// ===== src/dasc_core.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
// Function
// - four result channels, any modulator source
// - current gain 1..512, automatic or fixed
// - scaler keeps decimator lsb weight constant
// - other channel gain static power of two
// - chop: swap, negate, average two samples
// - software, timer or gpio start conversions
// - end of conversion is a trigger
// - dual target starts both converters together
// - arbiter launches only onto free converters
// - grant drives mux select of trigger
// - sync output fires own and remote triggers
// - one clock, fsm makes timing strobes
// - registers over bus, raise irq and dma
// - per converter analog and digital timing
// - modulator held in reset four cycles
// - conversion cycle lasts oversampling ratio clocks
// - continuous sinc4, valid from fourth cycle
// - incremental sinc3, result after three cycles
// - ratio 64 default sets result rates
// - alternating sources share incremental rate
// - high voltage divider 24x or 16x
// - any source routable to either converter
// - auto gain follows upper, lower thresholds
// - scaler shifts left up to nine bits
module dasc_core (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// apb slave
	input  wire logic [7:0]                  paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// trigger sources
	input  wire logic                        timer_trig,
	input  wire logic                        gpio_trig,
	input  wire logic                        sync_in,
	output logic                             sync_out,
	// modulator interface
	input  wire logic signed [3:0]           mod_data0,
	input  wire logic signed [3:0]           mod_data1,
	output logic      [dasc_pkg::NCV-1:0]    mod_reset,
	output logic      [dasc_pkg::NCV-1:0]    chop_swap,
	output logic      [dasc_pkg::NCV-1:0]    conv_strobe,
	output logic      [3:0]                  mux_sel0,
	output logic      [3:0]                  mux_sel1,
	output logic      [3:0]                  pga_gain0,
	output logic      [3:0]                  pga_gain1,
	output logic                             hv_div_16x,
	// requests
	output logic                             irq,
	output logic                             dma_req
);
	import dasc_pkg::*;

	// ==========================================
	// state
	logic [5:0]           ctrl_reg;
	logic [7:0]           osr_reg;
	logic [7:0]           gain_reg;
	logic [31:0]          agc_reg;
	logic [NSRC*TW-1:0]   trig_reg;
	logic [3:0]           route_reg;
	logic [31:0]          prdata_reg;
	logic                 pready_reg;
	logic                 pslverr_reg;
	logic [NSRC-1:0]      pend_reg;
	logic [2:0]           trig_prev_reg;
	logic                 sync_reg;
	dasc_st_e             st_reg [NCV];
	dasc_st_e             st_next [NCV];
	logic [7:0]           cnt_reg [NCV];
	logic [1:0]           ncv_reg [NCV];
	dasc_acc_t            integ_reg [NCV][4];
	dasc_acc_t            dly_reg [NCV][4];
	dasc_acc_t            sv_reg [NCV];
	logic [NCV-1:0]       ph_reg;
	logic [NCV-1:0]       mrst_reg;
	logic [NCV-1:0]       stb_reg;
	logic [3:0]           msel_reg [NCV];
	logic [3:0]           agexp_reg;
	logic [3:0]           gexp_reg [NCV];
	dasc_acc_t            firx_reg [2];
	logic [31:0]          res_reg [NCH];
	logic [NCH-1:0]       rdy_reg;
	logic                 irq_reg;
	logic                 dma_reg;
	logic                 hv_reg;

	// ==========================================
	// helper functions
	// gain weighting: one left shift per halving of gain, optional chop negate
	function automatic dasc_acc_t scale(input logic signed [3:0] d,
		input logic [3:0] sh, input logic neg);
		dasc_acc_t v;
		v = dasc_acc_t'(d);
		v = v <<< sh;
		scale = neg ? -v : v;
	endfunction

	// first pending source, lowest index wins, whose converters are all idle
	function automatic logic [NSRC-1:0] pick(input logic [NSRC-1:0] p,
		input logic [NSRC*TW-1:0] cfg, input logic [NCV-1:0] fr);
		logic [NSRC-1:0] g;
		logic            hit;
		g = '0;
		hit = 1'b0;
		for (int i = 0; i < NSRC; i++) begin
			if (!hit && p[i] && ((cfg[i*TW +: 2] & ~fr) == 2'h0)) begin
				g[i] = 1'b1;
				hit = 1'b1;
			end
		end
		pick = g;
	endfunction

	// ==========================================
	// apb decode
	wire       setup   = psel & ~penable;
	wire       acc     = psel & penable & pready_reg;
	wire       wr      = acc & pwrite;
	wire       rd      = acc & ~pwrite;
	wire       mapped  = (paddr[1:0] == 2'h0) && (paddr <= A_RES3);
	wire       is_res  = (paddr >= A_RES0) && mapped;
	wire       wr_cmd  = wr && (paddr == A_CMD);
	wire       incr    = ctrl_reg[CTRL_INCR];
	wire       chop_en = ctrl_reg[CTRL_CHOP];
	wire       agc_en  = ctrl_reg[CTRL_AGC];
	wire [1:0] busy    = {st_reg[1] != ST_IDLE, st_reg[0] != ST_IDLE};
	wire [31:0] stat_w = {12'h0, rdy_reg, pend_reg, ph_reg, gexp_reg[1], gexp_reg[0], busy};
	wire [31:0] rdata_w =
		(paddr == A_CTRL)  ? 32'(ctrl_reg)  :
		(paddr == A_OSR)   ? 32'(osr_reg)   :
		(paddr == A_GAIN)  ? 32'(gain_reg)  :
		(paddr == A_AGC)   ? agc_reg        :
		(paddr == A_TRIG)  ? 32'(trig_reg)  :
		(paddr == A_ROUTE) ? 32'(route_reg) :
		(paddr == A_STAT)  ? stat_w         :
		is_res             ? res_reg[paddr[3:2]] : 32'h0;

	// ==========================================
	// trigger capture and arbitration
	wire             sync_fire = wr_cmd & pwdata[CMD_SYNC] |
		(ctrl_reg[CTRL_SYNCT] & timer_trig & ~trig_prev_reg[0]);
	wire [NCV-1:0]   res_v;
	wire [NCV-1:0]   pub;
	wire [NSRC-1:0]  src_ev = {|res_v,
		(gpio_trig & ~trig_prev_reg[1]) | (sync_in & ~trig_prev_reg[2]) | sync_fire,
		timer_trig & ~trig_prev_reg[0],
		wr_cmd & pwdata[CMD_SW]};
	wire [NCV-1:0]   free = ~busy;
	wire [NSRC-1:0]  gnt  = pick(pend_reg, trig_reg, free);
	logic [NCV-1:0]  gnt_tgt;
	logic [3:0]      gnt_mux;
	logic [NSRC-1:0] src_ok;

	// selected target mask and input select of the granted source
	always_comb begin
		gnt_tgt = '0;
		gnt_mux = '0;
		for (int i = 0; i < NSRC; i++) begin
			src_ok[i] = |trig_reg[i*TW +: 2];
			if (gnt[i]) begin
				gnt_tgt = trig_reg[i*TW +: 2];
				gnt_mux = trig_reg[i*TW+2 +: 4];
			end
		end
	end

	// ==========================================
	// converter datapath
	wire logic signed [3:0] mdat [NCV];
	dasc_acc_t       xin [NCV];
	dasc_acc_t       cin [NCV][4];
	dasc_acc_t       cb [NCV][4];
	dasc_acc_t       dec [NCV];
	dasc_acc_t       pubv [NCV];
	logic [NCV-1:0]  stb;
	assign mdat[0] = mod_data0;
	assign mdat[1] = mod_data1;

	// scaler, comb section and sequencer next state per converter
	always_comb begin
		for (int c = 0; c < NCV; c++) begin
			xin[c] = scale(mdat[c], GEXP_MAX - gexp_reg[c], chop_en & ph_reg[c]);
			cin[c][0] = incr ? integ_reg[c][2] : integ_reg[c][3];
			for (int k = 0; k < 4; k++) begin
				if (k > 0)
					cin[c][k] = cb[c][k-1];
				cb[c][k] = cin[c][k] - dly_reg[c][k];
			end
			dec[c] = incr ? cb[c][2] : cb[c][3];
			pubv[c] = chop_en ? (sv_reg[c] + dec[c]) >>> 1 : dec[c];
			stb[c] = (st_reg[c] == ST_CONV) && (cnt_reg[c] == osr_reg - 8'h1);
			st_next[c] = st_reg[c];
			unique case (st_reg[c])
				ST_IDLE: begin
					if (gnt_tgt[c])
						st_next[c] = ST_RST;
				end
				ST_RST: begin
					if (cnt_reg[c] == MOD_RST_LAST)
						st_next[c] = ST_CONV;
				end
				ST_CONV: begin
					if (stb[c] && (incr ? ncv_reg[c] == 2'h2 : !ctrl_reg[CTRL_RUN]))
						st_next[c] = ST_IDLE;
				end
				default: st_next[c] = ST_IDLE;
			endcase
		end
	end
	assign res_v[0] = stb[0] && (ncv_reg[0] == (incr ? 2'h2 : 2'h3));
	assign res_v[1] = stb[1] && (ncv_reg[1] == (incr ? 2'h2 : 2'h3));
	assign pub = res_v & (~{NCV{chop_en}} | ph_reg);

	// ==========================================
	// automatic gain of the current path (converter 0)
	wire [31:0] mag    = pubv[0][31] ? -pubv[0][31:0] : pubv[0][31:0];
	wire        agc_up = (mag < {16'h0, agc_reg[31:16]}) && (agexp_reg < GEXP_MAX);
	wire        agc_dn = (mag > {16'h0, agc_reg[15:0]}) && (agexp_reg != 4'h0);
	wire [3:0]  fexp0  = (gain_reg[3:0] > GEXP_MAX) ? GEXP_MAX : gain_reg[3:0];
	wire [3:0]  fexp1  = (gain_reg[7:4] > GEXP_MAX) ? GEXP_MAX : gain_reg[7:4];

	// ==========================================
	// result channels
	logic [NCH-1:0] upd;
	dasc_acc_t      chv [NCH];
	wire [NCH-1:0]  rd_clr = {NCH{rd & is_res}} & (4'h1 << paddr[3:2]);

	// 0 and 1 carry a two-tap fir, 2 and 3 pass the sample straight
	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			upd[k] = pub[route_reg[k]];
			chv[k] = pubv[route_reg[k]];
			if (k < 2)
				chv[k] = (pubv[route_reg[k]] + firx_reg[k[0]]) >>> 1;
		end
	end

	// ==========================================
	// apb slave: no wait state, answer registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
			if (setup)
				prdata_reg <= mapped ? rdata_w : 32'h0;
		end
	end

	// software registers and arbitration state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg      <= CTRL_RST;
			osr_reg       <= OSR_RST;
			gain_reg      <= GAIN_RST;
			agc_reg       <= AGC_RST;
			trig_reg      <= TRIG_RST;
			route_reg     <= ROUTE_RST;
			pend_reg      <= '0;
			trig_prev_reg <= 3'h0;
			sync_reg      <= 1'b0;
			hv_reg        <= 1'b0;
		end else begin
			if (wr && paddr == A_CTRL)
				ctrl_reg <= pwdata[5:0];
			if (wr && paddr == A_OSR)
				osr_reg <= pwdata[7:0];
			if (wr && paddr == A_GAIN)
				gain_reg <= pwdata[7:0];
			if (wr && paddr == A_AGC)
				agc_reg <= pwdata;
			if (wr && paddr == A_TRIG)
				trig_reg <= pwdata[NSRC*TW-1:0];
			if (wr && paddr == A_ROUTE)
				route_reg <= pwdata[3:0];
			pend_reg      <= (pend_reg & ~gnt) | (src_ev & src_ok);
			trig_prev_reg <= {sync_in, gpio_trig, timer_trig};
			sync_reg      <= sync_fire;
			hv_reg        <= ctrl_reg[CTRL_HV16];
		end
	end

	// per converter sequencer, integrators and comb delays
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_reg    <= '0;
			mrst_reg  <= '0;
			stb_reg   <= '0;
			agexp_reg <= 4'h0;
			for (int c = 0; c < NCV; c++) begin
				st_reg[c]   <= ST_IDLE;
				cnt_reg[c]  <= 8'h0;
				ncv_reg[c]  <= 2'h0;
				sv_reg[c]   <= '0;
				msel_reg[c] <= 4'h0;
				gexp_reg[c] <= 4'h0;
				for (int k = 0; k < 4; k++) begin
					integ_reg[c][k] <= '0;
					dly_reg[c][k]   <= '0;
				end
			end
		end else begin
			if (agc_en && pub[0] && (agc_up || agc_dn))
				agexp_reg <= agc_up ? agexp_reg + 4'h1 : agexp_reg - 4'h1;
			gexp_reg[0] <= agc_en ? agexp_reg : fexp0;
			gexp_reg[1] <= fexp1;
			for (int c = 0; c < NCV; c++) begin
				st_reg[c]   <= st_next[c];
				mrst_reg[c] <= st_next[c] == ST_RST;
				stb_reg[c]  <= stb[c];
				if (gnt_tgt[c])
					msel_reg[c] <= gnt_mux;
				cnt_reg[c] <= (st_next[c] != st_reg[c] || stb[c]) ? 8'h0 : cnt_reg[c] + 8'h1;
				if (st_reg[c] == ST_RST) begin
					ncv_reg[c] <= 2'h0;
					for (int k = 0; k < 4; k++) begin
						integ_reg[c][k] <= '0;
						dly_reg[c][k]   <= '0;
					end
				end else if (st_reg[c] == ST_CONV) begin
					integ_reg[c][0] <= integ_reg[c][0] + xin[c];
					for (int k = 1; k < 4; k++)
						integ_reg[c][k] <= integ_reg[c][k] + integ_reg[c][k-1];
					if (stb[c]) begin
						ncv_reg[c] <= (ncv_reg[c] == 2'h3) ? 2'h3 : ncv_reg[c] + 2'h1;
						for (int k = 0; k < 4; k++)
							dly_reg[c][k] <= cin[c][k];
					end
				end
				if (res_v[c] && chop_en) begin
					ph_reg[c] <= ~ph_reg[c];
					sv_reg[c] <= dec[c];
				end
			end
		end
	end

	// result storage, ready flags (set wins over read clear), requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_reg <= '0;
			irq_reg <= 1'b0;
			dma_reg <= 1'b0;
			for (int k = 0; k < NCH; k++)
				res_reg[k] <= 32'h0;
			firx_reg[0] <= '0;
			firx_reg[1] <= '0;
		end else begin
			rdy_reg <= (rdy_reg & ~rd_clr) | upd;
			irq_reg <= |((rdy_reg & ~rd_clr) | upd);
			dma_reg <= |upd;
			for (int k = 0; k < NCH; k++) begin
				if (upd[k])
					res_reg[k] <= chv[k][31:0];
			end
			for (int k = 0; k < 2; k++) begin
				if (upd[k])
					firx_reg[k] <= pubv[route_reg[k]];
			end
		end
	end

	// ==========================================
	// outputs
	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign sync_out    = sync_reg;
	assign mod_reset   = mrst_reg;
	assign chop_swap   = ph_reg;
	assign conv_strobe = stb_reg;
	assign mux_sel0    = msel_reg[0];
	assign mux_sel1    = msel_reg[1];
	assign pga_gain0   = gexp_reg[0];
	assign pga_gain1   = gexp_reg[1];
	assign hv_div_16x  = hv_reg;
	assign irq         = irq_reg;
	assign dma_req     = dma_reg;

	// ==========================================
	// checks
	logic [8:0] gap_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap_reg <= 9'h0;
		else
			gap_reg <= mrst_reg[0] ? 9'h0 : stb_reg[0] ? 9'h1 : gap_reg + 9'h1;
	end

	default clocking cb_chk @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_rst4;
		mrst_reg[0] [*4] ##1 !mrst_reg[0];
	endsequence
	property p_rst_len;
		$rose(mrst_reg[0]) |-> s_rst4;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset not four cycles");
	property p_conv_len;
		stb_reg[0] && osr_reg != 8'h0 |-> gap_reg == {1'b0, osr_reg};
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	property p_dual;
		gnt_tgt == 2'h3 |=> mrst_reg == 2'h3;
	endproperty
	a_dual: assert property (p_dual) else $error("dual start not aligned");
	property p_mux;
		gnt_tgt[0] |=> mux_sel0 == $past(gnt_mux);
	endproperty
	a_mux: assert property (p_mux) else $error("mux not driven");
	property p_free;
		$rose(mrst_reg[1]) |-> $past(st_reg[1] == ST_IDLE);
	endproperty
	a_free: assert property (p_free) else $error("launch on busy converter");
	property p_keep;
		(pend_reg & ~gnt) != 4'h0 |=>
			(pend_reg & $past(pend_reg & ~gnt)) == $past(pend_reg & ~gnt);
	endproperty
	a_keep: assert property (p_keep) else $error("pending lost");
	property p_gain;
		pga_gain0 <= GEXP_MAX && pga_gain1 <= GEXP_MAX;
	endproperty
	a_gain: assert property (p_gain) else $error("gain out of range");
	property p_chop;
		res_v[0] && chop_en |=> chop_swap[0] != $past(chop_swap[0]);
	endproperty
	a_chop: assert property (p_chop) else $error("chop phase stuck");
	property p_incr;
		res_v[0] && incr |=> st_reg[0] == ST_IDLE ##1 !conv_strobe[0];
	endproperty
	a_incr: assert property (p_incr) else $error("one-shot did not stop");
	property p_sync;
		sync_fire |=> sync_out && pend_reg[SRC_GPIO] == src_ok[SRC_GPIO];
	endproperty
	a_sync: assert property (p_sync) else $error("sync not self triggering");
endmodule

// ===== test/dasc_front_model.sv
`timescale 1ns/10ps
// ==========================================
// far side: timer, gpio pad, sync line and modulator bitstreams
module dasc_front_model (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// requests from the bench
	input  wire logic             fire_tmr,
	input  wire logic             fire_gpio,
	input  wire logic             fire_sync,
	// lines into the block
	output logic                  timer_trig,
	output logic                  gpio_trig,
	output logic                  sync_in,
	output logic signed [3:0]     mod_data0,
	output logic signed [3:0]     mod_data1
);
	logic [2:0] ph_reg;
	// trigger lines follow the bench, sync_in is the pulse of a remote master chip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_trig <= 1'b0;
			gpio_trig  <= 1'b0;
			sync_in    <= 1'b0;
			ph_reg     <= 3'h0;
		end else begin
			timer_trig <= fire_tmr;
			gpio_trig  <= fire_gpio;
			sync_in    <= fire_sync;
			ph_reg     <= ph_reg + 3'h1;
		end
	end
	// bitstream 0 changes every cycle, bitstream 1 every two, so a stale sample never looks valid
	assign mod_data0 = ph_reg[0] ? 4'sh3 : 4'she;
	assign mod_data1 = ph_reg[1] ? 4'sh5 : 4'shf;
endmodule

// ===== test/dual_adc_sequencer_channels_tb.sv
`timescale 1ns/10ps
// ==========================================
// bench for the conversion sequencer
module dual_adc_sequencer_channels_tb;
	import dasc_pkg::*;
	localparam int OVERSAMPLING_RATIO = 8;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        fire_tmr = 1'b0;
	logic        fire_gpio = 1'b0;
	logic        fire_sync = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        timer_trig;
	logic        gpio_trig;
	logic        sync_in;
	logic        sync_out;
	logic signed [3:0] mod_data0;
	logic signed [3:0] mod_data1;
	logic [1:0]  mod_reset;
	logic [1:0]  chop_swap;
	logic [1:0]  conv_strobe;
	logic [3:0]  mux_sel0;
	logic [3:0]  mux_sel1;
	logic [3:0]  pga_gain0;
	logic [3:0]  pga_gain1;
	logic        hv_div_16x;
	logic        irq;
	logic        dma_req;
	logic [31:0] rd;
	logic        er;
	int          num_errors = 0;
	int          n_checks = 0;

	// clock
	always #5 pclk = ~pclk;

	dasc_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_trig(timer_trig),
		.gpio_trig(gpio_trig), .sync_in(sync_in), .sync_out(sync_out),
		.mod_data0(mod_data0), .mod_data1(mod_data1), .mod_reset(mod_reset),
		.chop_swap(chop_swap), .conv_strobe(conv_strobe), .mux_sel0(mux_sel0),
		.mux_sel1(mux_sel1), .pga_gain0(pga_gain0), .pga_gain1(pga_gain1),
		.hv_div_16x(hv_div_16x), .irq(irq), .dma_req(dma_req));

	dasc_front_model front (.pclk(pclk), .presetn(presetn), .fire_tmr(fire_tmr),
		.fire_gpio(fire_gpio), .fire_sync(fire_sync), .timer_trig(timer_trig),
		.gpio_trig(gpio_trig), .sync_in(sync_in), .mod_data0(mod_data0),
		.mod_data1(mod_data1));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("Error pready expected 1 seen %b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: pick = mod_reset[0];
			1: pick = dma_req;
			2: pick = conv_strobe[0];
			default: pick = sync_out;
		endcase
	endfunction

	// bounded wait for an output, sampled once settled
	task automatic wait_for(input int sel, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (pick(sel) !== 1'b1 && n < lim);
		if (n >= lim) begin
			num_errors++;
			$display("Error wait %0d expected 1 seen 0", sel);
		end
	endtask

	// one far side trigger pulse: 0 timer, 1 gpio, 2 remote sync
	task automatic pulse_tmr(input logic [1:0] g);
		@(posedge pclk);
		fire_tmr  <= (g == 2'h0);
		fire_gpio <= (g == 2'h1);
		fire_sync <= (g == 2'h2);
		repeat (2) @(posedge pclk);
		fire_tmr  <= 1'b0;
		fire_gpio <= 1'b0;
		fire_sync <= 1'b0;
	endtask

	task automatic t_reset();
		logic [7:0]  ad [5] = '{A_CTRL, A_OSR, A_AGC, A_TRIG, A_ROUTE};
		logic [31:0] ex [5] = '{32'(CTRL_RST), 32'(OSR_RST), AGC_RST, 32'(TRIG_RST),
			32'(ROUTE_RST)};
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ad[i], 32'h0);
			chk("reset value", rd, ex[i]);
		end
		apb(1'b0, A_OSR, 32'h0);
		chk("osr default", rd, 32'h0000_0040);
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, 8'h31, 32'hffff_ffff);
		chk("unaligned err", 32'(er), 32'h1);
	endtask

	task automatic t_gain();
		apb(1'b1, A_CTRL, 32'h0000_0009);
		apb(1'b1, A_GAIN, 32'h0000_00f6);
		repeat (3) @(posedge pclk);
		#1;
		chk("fixed gain", 32'(pga_gain0), 32'h6);
		chk("static clamp", 32'(pga_gain1), 32'h9);
		chk("divider 16x", 32'(hv_div_16x), 32'h1);
		apb(1'b1, A_CTRL, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		#1;
		chk("divider 24x", 32'(hv_div_16x), 32'h0);
	endtask

	task automatic t_timer();
		int n;
		apb(1'b1, A_OSR, 32'(OVERSAMPLING_RATIO));
		apb(1'b1, A_TRIG, 32'h0000_0540);
		pulse_tmr(2'h0);
		wait_for(0, 20);
		chk("timer mux", 32'(mux_sel0), 32'h5);
		n = 1;
		while (mod_reset[0] === 1'b1 && n < 20) begin
			@(posedge pclk);
			#1;
			if (mod_reset[0] === 1'b1) n++;
		end
		chk("reset length", 32'(n), 32'h4);
		wait_for(2, 50);
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (conv_strobe[0] !== 1'b1 && n < 50);
		chk("cycle length", 32'(n), 32'(OVERSAMPLING_RATIO));
		wait_for(1, 50);
		chk("third strobe", 32'(conv_strobe[0]), 32'h1);
		repeat (2) @(posedge pclk);
		#1;
		chk("irq set", 32'(irq), 32'h1);
		n = 0;
		repeat (3 * OVERSAMPLING_RATIO) begin
			@(posedge pclk);
			#1;
			if (conv_strobe[0] === 1'b1) n++;
		end
		chk("one shot idle", 32'(n), 32'h0);
		apb(1'b0, A_STAT, 32'h0);
		chk("ready route", 32'(rd[19:16]), 32'h5);
		apb(1'b0, A_RES0, 32'h0);
		apb(1'b0, A_RES0 + 8'h08, 32'h0);
		repeat (3) @(posedge pclk);
		#1;
		chk("irq clear", 32'(irq), 32'h0);
	endtask

	task automatic t_dual();
		apb(1'b1, A_TRIG, 32'h0000_000b);
		apb(1'b1, A_CMD, 32'h0000_0001);
		wait_for(0, 20);
		chk("both start", 32'(mod_reset), 32'h3);
		chk("mux conv0", 32'(mux_sel0), 32'h2);
		chk("mux conv1", 32'(mux_sel1), 32'h2);
		wait_for(1, 100);
		apb(1'b0, A_STAT, 32'h0);
		chk("all ready", 32'(rd[19:16]), 32'hf);
		for (int k = 0; k < 4; k++) apb(1'b0, A_RES0 + 8'(4 * k), 32'h0);
	endtask

	task automatic t_pend();
		apb(1'b1, A_TRIG, 32'h0001_d00d);
		apb(1'b1, A_CMD, 32'h0000_0001);
		wait_for(0, 20);
		chk("sw mux", 32'(mux_sel0), 32'h3);
		pulse_tmr(2'h1);
		apb(1'b0, A_STAT, 32'h0);
		chk("gpio pending", 32'(rd[14]), 32'h1);
		chk("mux held", 32'(mux_sel0), 32'h3);
		wait_for(1, 100);
		wait_for(0, 20);
		chk("gpio mux", 32'(mux_sel0), 32'h7);
		wait_for(1, 100);
	endtask

	task automatic t_sync();
		apb(1'b1, A_CMD, 32'h0000_0002);
		#1;
		chk("sync pulse", 32'(sync_out), 32'h1);
		apb(1'b0, A_STAT, 32'h0);
		chk("sync busy", 32'(rd[0]), 32'h1);
		wait_for(0, 20);
		chk("sync start", 32'(mux_sel0), 32'h7);
		wait_for(1, 100);
		pulse_tmr(2'h2);
		wait_for(0, 20);
		chk("remote sync", 32'(mux_sel0), 32'h7);
		wait_for(1, 100);
	endtask

	task automatic t_cont();
		int s;
		int n;
		s = 0;
		n = 0;
		apb(1'b1, A_CTRL, 32'h0000_0014);
		apb(1'b1, A_CMD, 32'h0000_0001);
		wait_for(0, 20);
		chk("auto gain", 32'(pga_gain0), 32'h0);
		while (dma_req !== 1'b1 && n < 200) begin
			@(posedge pclk);
			#1;
			n++;
			if (conv_strobe[0] === 1'b1) s++;
		end
		chk("first valid", 32'(s), 32'h4);
		wait_for(1, OVERSAMPLING_RATIO + 4);
		apb(1'b1, A_CTRL, 32'h0000_0012);
		wait_for(1, 3 * OVERSAMPLING_RATIO);
		chk("chop publish", 32'(chop_swap[0]), 32'h0);
		repeat (OVERSAMPLING_RATIO) @(posedge pclk);
		#1;
		chk("chop swapped", 32'(chop_swap[0]), 32'h1);
		chk("chop held back", 32'(dma_req), 32'h0);
		apb(1'b1, A_CTRL, 32'h0000_0000);
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_gain();
		t_timer();
		t_dual();
		t_pend();
		t_sync();
		t_cont();
		results();
	end

	// watchdog against a hung handshake
	initial begin
		#300us;
		num_errors++;
		results();
	end
endmodule
